// [rtl/dtc_regs.vh]
// register map, field positions, reset values and timing counts for the dual timer/counter
// assumes a processor core that reaches these registers by an 8-bit special function register address
`ifndef DTC_REGS_VH
`define DTC_REGS_VH

`define DTC_ADDR_CONTROL 8'h88
`define DTC_ADDR_MODE 8'h89
`define DTC_ADDR_LOW0 8'h8a
`define DTC_ADDR_LOW1 8'h8b
`define DTC_ADDR_HIGH0 8'h8c
`define DTC_ADDR_HIGH1 8'h8d

// control register fields
`define DTC_CTL_OVF1 7
`define DTC_CTL_RUN1 6
`define DTC_CTL_OVF0 5
`define DTC_CTL_RUN0 4
`define DTC_CTL_XFLAG1 3
`define DTC_CTL_XTYPE1 2
`define DTC_CTL_XFLAG0 1
`define DTC_CTL_XTYPE0 0

// mode register fields
`define DTC_MOD_GATE_ENABLE_UNIT1 7
`define DTC_MOD_SEL1 6
`define DTC_MOD_M1_HI 5
`define DTC_MOD_M1_LO 4
`define DTC_MOD_GATE_ENABLE_UNIT0 3
`define DTC_MOD_SEL0 2
`define DTC_MOD_M0_HI 1
`define DTC_MOD_M0_LO 0

`define DTC_MODE_13BIT 2'h0
`define DTC_MODE_16BIT 2'h1
`define DTC_MODE_RELOAD 2'h2
`define DTC_MODE_SPLIT 2'h3

`define DTC_RST_CONTROL 8'h00
`define DTC_RST_MODE 8'h00
`define DTC_RST_COUNT 8'h00

// oscillator clocks per machine cycle
`define DTC_MC_DIV 4'hc
`define DTC_MC_LAST 4'hb

`endif

// [rtl/dtc_sync.v]
// two-flop synchroniser for a group of asynchronous pin levels
// assumes each bit is an independent level; no bus coherency is implied
`timescale 1ns/1ps
module dtc_sync #(
  parameter W = 4
) (
  sys_clk,
  rst,
  d,
  q
);
  input wire sys_clk;
  input wire rst;
  input wire [W-1:0] d;
  output reg [W-1:0] q;

  reg [W-1:0] meta;

  // first stage is read by the second stage only
  always @(posedge sys_clk) begin
    if (rst) begin
      meta <= {W{1'b1}};
      q <= {W{1'b1}};
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// [rtl/dtc_timer_top.v]
// two 16-bit timer/counters with mode, run/flag control and external interrupt flags
// assumes the processor core is on sys_clk, issues one-cycle write strobes and service acks,
// and that the four pins are asynchronous and pass a synchroniser here
`timescale 1ns/1ps
`include "dtc_regs.vh"
module dtc_timer_top (
  sys_clk,
  rst,
  sfr_addr,
  sfr_wr,
  sfr_wdata,
  sfr_rdata,
  ext_irq_pin_0,
  ext_irq_pin_1,
  count_input_unit0,
  count_input_unit1,
  ack_overflow_unit0,
  ack_overflow_unit1,
  ack_ext_irq_0,
  ack_ext_irq_1,
  irq_overflow_unit0,
  irq_overflow_unit1,
  irq_ext_0,
  irq_ext_1,
  baud_tick_unit1
);
  input wire sys_clk;
  input wire rst;
  input wire [7:0] sfr_addr;
  input wire sfr_wr;
  input wire [7:0] sfr_wdata;
  output reg [7:0] sfr_rdata;
  input wire ext_irq_pin_0;
  input wire ext_irq_pin_1;
  input wire count_input_unit0;
  input wire count_input_unit1;
  input wire ack_overflow_unit0;
  input wire ack_overflow_unit1;
  input wire ack_ext_irq_0;
  input wire ack_ext_irq_1;
  output reg irq_overflow_unit0;
  output reg irq_overflow_unit1;
  output reg irq_ext_0;
  output reg irq_ext_1;
  output reg baud_tick_unit1;

  // one step of a counter; returns {overflow, new count}
  function [16:0] count_step;
    input [1:0] mode;
    input [15:0] cnt;
    reg [13:0] wide13;
    reg [8:0] low9;
    begin
      wide13 = {1'b0, cnt[15:8], cnt[4:0]} + 14'h0001;
      low9 = {1'b0, cnt[7:0]} + 9'h001;
      case (mode)
        `DTC_MODE_13BIT: begin
          // upper three bits of the low byte are left alone
          count_step = {wide13[13], wide13[12:5], cnt[7:5], wide13[4:0]};
        end
        `DTC_MODE_16BIT: begin
          count_step = {1'b0, cnt} + 17'h00001;
        end
        `DTC_MODE_RELOAD: begin
          if (low9[8]) begin
            count_step = {1'b1, cnt[15:8], cnt[15:8]};
          end else begin
            count_step = {1'b0, cnt[15:8], low9[7:0]};
          end
        end
        default: begin
          // split mode: low byte alone, high byte handled by the caller
          count_step = {low9[8], cnt[15:8], low9[7:0]};
        end
      endcase
    end
  endfunction

  // write strobe for one register address
  function wr_hit;
    input wr;
    input [7:0] addr;
    input [7:0] target;
    begin
      wr_hit = wr & (addr == target);
    end
  endfunction

  // one machine-cycle sample against the previous one:
  // a falling edge when edge_only is set, otherwise any low sample
  function trig_hit;
    input edge_only;
    input tick;
    input prev;
    input now;
    begin
      trig_hit = tick & ~now & (prev | ~edge_only);
    end
  endfunction

  // a unit may count while its run bit is set and, if gated, its pin is high
  function unit_allow;
    input run;
    input gate;
    input pin;
    begin
      unit_allow = run & (~gate | pin);
    end
  endfunction

  wire [3:0] pins_s;
  wire xpin0 = pins_s[0];
  wire xpin1 = pins_s[1];
  wire tin0 = pins_s[2];
  wire tin1 = pins_s[3];

  dtc_sync #(
    .W(4)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .d({count_input_unit1, count_input_unit0, ext_irq_pin_1, ext_irq_pin_0}),
    .q(pins_s)
  );

  reg [7:0] timer_mode_select;
  reg overflow_flag_unit1;
  reg run_bit_unit1;
  reg overflow_flag_unit0;
  reg run_bit_unit0;
  reg ext_irq_flag_1;
  reg ext_irq_type_1;
  reg ext_irq_flag_0;
  reg ext_irq_type_0;
  reg [7:0] count_low_byte_unit0;
  reg [7:0] count_high_byte_unit0;
  reg [7:0] count_low_byte_unit1;
  reg [7:0] count_high_byte_unit1;

  reg [3:0] mc_cnt;
  reg mc_tick;
  reg [3:0] smp;

  // machine cycle strobe: one sys_clk pulse every twelve
  always @(posedge sys_clk) begin
    if (rst) begin
      mc_cnt <= 4'h0;
      mc_tick <= 1'b0;
    end else begin
      mc_tick <= (mc_cnt == `DTC_MC_LAST);
      if (mc_cnt == `DTC_MC_LAST) begin
        mc_cnt <= 4'h0;
      end else begin
        mc_cnt <= mc_cnt + 4'h1;
      end
    end
  end

  // pins are looked at once per machine cycle; previous sample kept in smp
  // a level shorter than one machine cycle can slip between samples
  wire cnt_ev0 = trig_hit(1'b1, mc_tick, smp[2], tin0);
  wire cnt_ev1 = trig_hit(1'b1, mc_tick, smp[3], tin1);

  always @(posedge sys_clk) begin
    if (rst) begin
      smp <= 4'hf;
    end else if (mc_tick) begin
      smp <= pins_s;
    end
  end

  wire [1:0] mode0 = timer_mode_select[`DTC_MOD_M0_HI:`DTC_MOD_M0_LO];
  wire [1:0] mode1 = timer_mode_select[`DTC_MOD_M1_HI:`DTC_MOD_M1_LO];
  wire split0 = (mode0 == `DTC_MODE_SPLIT);
  wire gate_enable_unit0 = timer_mode_select[`DTC_MOD_GATE_ENABLE_UNIT0];
  wire gate_enable_unit1 = timer_mode_select[`DTC_MOD_GATE_ENABLE_UNIT1];
  wire sel0 = timer_mode_select[`DTC_MOD_SEL0];
  wire sel1 = timer_mode_select[`DTC_MOD_SEL1];

  // source pulse: external event or machine cycle
  wire src0 = sel0 ? cnt_ev0 : mc_tick;
  wire src1 = sel1 ? cnt_ev1 : mc_tick;
  // the gate pin is read every clock, not only at machine-cycle samples
  wire allow0 = unit_allow(run_bit_unit0, gate_enable_unit0, xpin0);
  wire allow1 = unit_allow(run_bit_unit1, gate_enable_unit1, xpin1);

  wire inc0 = allow0 & src0;
  // while unit 0 is split, unit 1 loses its run bit and flag, so it free-runs unless it is in split mode itself, where it stops
  wire inc1 = (mode1 != `DTC_MODE_SPLIT) & (split0 ? src1 : (allow1 & src1));
  // split high byte always counts machine cycles under run bit 1
  wire inc0_hi = split0 & run_bit_unit1 & mc_tick;

  wire [16:0] step0 = count_step(mode0, {count_high_byte_unit0, count_low_byte_unit0});
  wire [16:0] step1 = count_step(mode1, {count_high_byte_unit1, count_low_byte_unit1});
  wire [8:0] step0_hi = {1'b0, count_high_byte_unit0} + 9'h001;

  wire ovf0 = inc0 & step0[16];
  wire ovf0_hi = inc0_hi & step0_hi[8];
  wire ovf1 = inc1 & step1[16];
  // unit 1 overflow still feeds the bit-rate tick while unit 0 owns its flag
  wire set_tf1 = split0 ? ovf0_hi : ovf1;

  // unmapped addresses match no strobe, so their writes are dropped
  wire wr_ctl = wr_hit(sfr_wr, sfr_addr, `DTC_ADDR_CONTROL);
  wire wr_mod = wr_hit(sfr_wr, sfr_addr, `DTC_ADDR_MODE);
  wire wr_tl0 = wr_hit(sfr_wr, sfr_addr, `DTC_ADDR_LOW0);
  wire wr_th0 = wr_hit(sfr_wr, sfr_addr, `DTC_ADDR_HIGH0);
  wire wr_tl1 = wr_hit(sfr_wr, sfr_addr, `DTC_ADDR_LOW1);
  wire wr_th1 = wr_hit(sfr_wr, sfr_addr, `DTC_ADDR_HIGH1);

  // external interrupt trigger: low level or falling edge
  wire xset0 = trig_hit(ext_irq_type_0, mc_tick, smp[0], xpin0);
  wire xset1 = trig_hit(ext_irq_type_1, mc_tick, smp[1], xpin1);

  // counters; a software write wins over an increment in the same cycle
  always @(posedge sys_clk) begin
    if (rst) begin
      count_low_byte_unit0 <= `DTC_RST_COUNT;
      count_high_byte_unit0 <= `DTC_RST_COUNT;
      count_low_byte_unit1 <= `DTC_RST_COUNT;
      count_high_byte_unit1 <= `DTC_RST_COUNT;
    end else begin
      if (wr_tl0) begin
        count_low_byte_unit0 <= sfr_wdata;
      end else if (inc0) begin
        count_low_byte_unit0 <= step0[7:0];
      end
      if (wr_th0) begin
        count_high_byte_unit0 <= sfr_wdata;
      end else if (inc0_hi) begin
        count_high_byte_unit0 <= step0_hi[7:0];
      end else if (inc0 & ~split0) begin
        count_high_byte_unit0 <= step0[15:8];
      end
      if (wr_tl1) begin
        count_low_byte_unit1 <= sfr_wdata;
      end else if (inc1) begin
        count_low_byte_unit1 <= step1[7:0];
      end
      if (wr_th1) begin
        count_high_byte_unit1 <= sfr_wdata;
      end else if (inc1) begin
        count_high_byte_unit1 <= step1[15:8];
      end
    end
  end

  // mode register and control bits; hardware set beats software clear and ack
  always @(posedge sys_clk) begin
    if (rst) begin
      timer_mode_select <= `DTC_RST_MODE;
      overflow_flag_unit1 <= 1'b0;
      run_bit_unit1 <= 1'b0;
      overflow_flag_unit0 <= 1'b0;
      run_bit_unit0 <= 1'b0;
      ext_irq_flag_1 <= 1'b0;
      ext_irq_type_1 <= 1'b0;
      ext_irq_flag_0 <= 1'b0;
      ext_irq_type_0 <= 1'b0;
    end else begin
      if (wr_mod) begin
        timer_mode_select <= sfr_wdata;
      end
      if (wr_ctl) begin
        run_bit_unit1 <= sfr_wdata[`DTC_CTL_RUN1];
        run_bit_unit0 <= sfr_wdata[`DTC_CTL_RUN0];
        ext_irq_type_1 <= sfr_wdata[`DTC_CTL_XTYPE1];
        ext_irq_type_0 <= sfr_wdata[`DTC_CTL_XTYPE0];
      end
      // writing 1 to a flag raises it, so software can post an interrupt
      if (set_tf1) begin
        overflow_flag_unit1 <= 1'b1;
      end else if (ack_overflow_unit1) begin
        overflow_flag_unit1 <= 1'b0;
      end else if (wr_ctl) begin
        overflow_flag_unit1 <= sfr_wdata[`DTC_CTL_OVF1];
      end
      if (ovf0) begin
        overflow_flag_unit0 <= 1'b1;
      end else if (ack_overflow_unit0) begin
        overflow_flag_unit0 <= 1'b0;
      end else if (wr_ctl) begin
        overflow_flag_unit0 <= sfr_wdata[`DTC_CTL_OVF0];
      end
      if (xset1) begin
        ext_irq_flag_1 <= 1'b1;
      end else if (ack_ext_irq_1 & ext_irq_type_1) begin
        ext_irq_flag_1 <= 1'b0;
      end else if (wr_ctl) begin
        // level-triggered flags only leave through this write
        ext_irq_flag_1 <= sfr_wdata[`DTC_CTL_XFLAG1];
      end
      if (xset0) begin
        ext_irq_flag_0 <= 1'b1;
      end else if (ack_ext_irq_0 & ext_irq_type_0) begin
        ext_irq_flag_0 <= 1'b0;
      end else if (wr_ctl) begin
        ext_irq_flag_0 <= sfr_wdata[`DTC_CTL_XFLAG0];
      end
    end
  end

  // outputs, each one register stage behind the state it mirrors
  always @(posedge sys_clk) begin
    if (rst) begin
      sfr_rdata <= 8'h00;
      irq_overflow_unit0 <= 1'b0;
      irq_overflow_unit1 <= 1'b0;
      irq_ext_0 <= 1'b0;
      irq_ext_1 <= 1'b0;
      baud_tick_unit1 <= 1'b0;
    end else begin
      irq_overflow_unit0 <= overflow_flag_unit0;
      irq_overflow_unit1 <= overflow_flag_unit1;
      irq_ext_0 <= ext_irq_flag_0;
      irq_ext_1 <= ext_irq_flag_1;
      baud_tick_unit1 <= ovf1;
      case (sfr_addr)
        `DTC_ADDR_CONTROL: begin
          sfr_rdata <= {overflow_flag_unit1, run_bit_unit1, overflow_flag_unit0, run_bit_unit0,
                        ext_irq_flag_1, ext_irq_type_1, ext_irq_flag_0, ext_irq_type_0};
        end
        `DTC_ADDR_MODE: begin
          sfr_rdata <= timer_mode_select;
        end
        `DTC_ADDR_LOW0: begin
          sfr_rdata <= count_low_byte_unit0;
        end
        `DTC_ADDR_LOW1: begin
          sfr_rdata <= count_low_byte_unit1;
        end
        `DTC_ADDR_HIGH0: begin
          sfr_rdata <= count_high_byte_unit0;
        end
        `DTC_ADDR_HIGH1: begin
          sfr_rdata <= count_high_byte_unit1;
        end
        default: begin
          // unmapped addresses read zero
          sfr_rdata <= 8'h00;
        end
      endcase
    end
  end
endmodule

// [tb/dtc_pin_model.sv]
// pin-side model: external count sources and interrupt lines feeding the timer block
// assumes the bench calls its tasks; every line idles high as if pulled up
`timescale 1ns/1ps
module dtc_pin_model (
  input wire sys_clk,
  output reg [1:0] ext_pin,
  output reg [1:0] cnt_pin
);
  initial begin
    ext_pin = 2'h3;
    cnt_pin = 2'h3;
  end
  // each level lasts 30 clocks, more than the one machine cycle the sampler needs
  task count_events(input int u, input int n);
    int i;
    for (i = 0; i < n; i++) begin
      @(negedge sys_clk) cnt_pin[u] = 1'b0;
      repeat (30) @(negedge sys_clk);
      cnt_pin[u] = 1'b1;
      repeat (30) @(negedge sys_clk);
    end
  endtask
  // settles through the synchroniser and one machine cycle before returning
  task set_ext(input int k, input bit v);
    @(negedge sys_clk) ext_pin[k] = v;
    repeat (16) @(negedge sys_clk);
  endtask
endmodule

// [tb/dtc_timer_sva.sv]
// checker for the timer block: ties irq copies, reads and acks together
// assumes it is bound to dtc_timer_top and sees only its ports
`timescale 1ns/1ps
module dtc_timer_sva (
  input wire sys_clk,
  input wire rst,
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire [7:0] sfr_wdata,
  input wire [7:0] sfr_rdata,
  input wire ack_overflow_unit0,
  input wire ack_overflow_unit1,
  input wire irq_overflow_unit0,
  input wire irq_overflow_unit1,
  input wire irq_ext_0,
  input wire irq_ext_1,
  input wire baud_tick_unit1
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence ctl_read;
    !$past(rst) && $past(sfr_addr) == 8'h88;
  endsequence
  sequence mode_wr_rd;
    sfr_wr && sfr_addr == 8'h89 ##1 !sfr_wr && sfr_addr == 8'h89;
  endsequence
  a_ovf0_read_match: assert property (ctl_read |-> sfr_rdata[5] == irq_overflow_unit0)
    else $error("ovf0 flag and irq differ");
  a_ovf1_read_match: assert property (ctl_read |-> sfr_rdata[7] == irq_overflow_unit1)
    else $error("ovf1 flag and irq differ");
  a_ext0_read_match: assert property (ctl_read |-> sfr_rdata[1] == irq_ext_0)
    else $error("ext0 flag and irq differ");
  a_ext1_read_match: assert property (ctl_read |-> sfr_rdata[3] == irq_ext_1)
    else $error("ext1 flag and irq differ");
  a_ack0_clears_ovf: assert property (ack_overflow_unit0 && !sfr_wr |-> ##2 !irq_overflow_unit0)
    else $error("ack left ovf0 set");
  a_ack1_clears_ovf: assert property (ack_overflow_unit1 && !sfr_wr |-> ##2 !irq_overflow_unit1)
    else $error("ack left ovf1 set");
  a_mode_read_back: assert property (mode_wr_rd |=> sfr_rdata == $past(sfr_wdata, 2))
    else $error("mode read back wrong");
  a_baud_tick_spacing: assert property (baud_tick_unit1 |=> (!baud_tick_unit1) [*8])
    else $error("baud ticks too close");
  c_ovf0: cover property ($rose(irq_overflow_unit0));
  c_ovf1: cover property ($rose(irq_overflow_unit1));
  c_ext0: cover property ($rose(irq_ext_0));
  c_baud: cover property (baud_tick_unit1);
endmodule
bind dtc_timer_top dtc_timer_sva u_sva (.sys_clk(sys_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
  .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .ack_overflow_unit0(ack_overflow_unit0),
  .ack_overflow_unit1(ack_overflow_unit1), .irq_overflow_unit0(irq_overflow_unit0),
  .irq_overflow_unit1(irq_overflow_unit1), .irq_ext_0(irq_ext_0), .irq_ext_1(irq_ext_1),
  .baud_tick_unit1(baud_tick_unit1));

// [tb/test_dual_timer_counter_ext_irq.sv]
// self-checking bench for the dual timer/counter through its register port
// assumes a 40 MHz clock and the pin model as the only pin source
`timescale 1ns/1ps
module test_dual_timer_counter_ext_irq;
  logic sys_clk, rst, wr_en;
  logic [7:0] addr, wdata, rdata, v;
  logic [3:0] acks;
  wire [1:0] irq_ovf, irq_ext, ext_pin, cnt_pin;
  wire baud;
  wire [4:0] mon = {baud, irq_ext, irq_ovf};
  int mismatches, check_count, i, k;
  time t0, tdet;
  logic [7:0] cm[3] = '{8'h00, 8'h01, 8'h02};
  logic [7:0] chi[3] = '{8'hff, 8'hff, 8'hf0};
  logic [7:0] elo[3] = '{8'he0, 8'h00, 8'hf0};
  dtc_pin_model pm (.sys_clk(sys_clk), .ext_pin(ext_pin), .cnt_pin(cnt_pin));
  dtc_timer_top DUT (.sys_clk(sys_clk), .rst(rst), .sfr_addr(addr), .sfr_wr(wr_en), .sfr_wdata(wdata),
    .sfr_rdata(rdata), .ext_irq_pin_0(ext_pin[0]), .ext_irq_pin_1(ext_pin[1]),
    .count_input_unit0(cnt_pin[0]), .count_input_unit1(cnt_pin[1]),
    .ack_overflow_unit0(acks[0]), .ack_overflow_unit1(acks[1]), .ack_ext_irq_0(acks[2]),
    .ack_ext_irq_1(acks[3]), .irq_overflow_unit0(irq_ovf[0]), .irq_overflow_unit1(irq_ovf[1]),
    .irq_ext_0(irq_ext[0]), .irq_ext_1(irq_ext[1]), .baud_tick_unit1(baud));
  always #12.5 sys_clk = ~sys_clk;
  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    @(negedge sys_clk);
    wr_en = 1'b0;
  endtask
  // read data is registered, so it is taken one clock after the address
  task rc(input logic [7:0] a, input logic [7:0] exp);
    @(negedge sys_clk);
    addr = a;
    @(negedge sys_clk);
    chk(rdata, exp);
  endtask
  task ack(input int n);
    @(negedge sys_clk) acks[n] = 1'b1;
    @(negedge sys_clk) acks[n] = 1'b0;
  endtask
  task wait_bit(input int b, input int lim);
    int n;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
      if (n > lim) begin
        mismatches++;
        $display("MISMATCH t=%0t no event on %0d", $time, b);
        print_verdict;
      end
    end while (mon[b] !== 1'b1);
    tdet = $time;
  endtask
  initial begin
    sys_clk = 0;
    rst = 1;
    wr_en = 0;
    addr = 0;
    wdata = 0;
    acks = 0;
    repeat (2) @(negedge sys_clk);
    rst = 0;
    for (i = 0; i < 6; i++) rc(8'h88 + i[7:0], 8'h00);
    wr(8'h80, 8'hff);
    rc(8'h80, 8'h00);
    for (i = 0; i < 4; i++) begin
      v = 8'hcc ^ (8'h11 * i[7:0]);
      wr(8'h89, v);
      rc(8'h89, v);
    end
    $display("registers done");
    for (i = 0; i < 3; i++) begin
      wr(8'h89, cm[i]);
      wr(8'h8c, chi[i]);
      wr(8'h8a, 8'hff);
      wr(8'h88, 8'h10);
      wait_bit(0, 40);
      ack(0);
      @(negedge sys_clk);
      chk({7'h0, irq_ovf[0]}, 8'h00);
      wr(8'h88, 8'h00);
      rc(8'h8a, elo[i]);
      rc(8'h8c, cm[i] == 8'h02 ? 8'hf0 : 8'h00);
    end
    wr(8'h88, 8'h10);
    wait_bit(0, 300);
    t0 = tdet;
    ack(0);
    wait_bit(0, 300);
    chk(8'((tdet - t0) / 25), 8'hc0);
    wr(8'h88, 8'h00);
    $display("modes done");
    // both units as gated event counters in 16-bit mode
    for (k = 0; k < 2; k++) begin
      wr(8'h89, k ? 8'hd0 : 8'h0d);
      for (i = 0; i < 3; i++) begin
        wr(8'h8a + k[7:0], 8'h00);
        pm.set_ext(k, i != 1);
        wr(8'h88, i != 2 ? (8'h10 << (2 * k)) : 8'h00);
        pm.count_events(k, 3);
        rc(8'h8a + k[7:0], i == 0 ? 8'h03 : 8'h00);
      end
      pm.set_ext(k, 1);
    end
    $display("events done");
    wr(8'h89, 8'h33);
    wr(8'h8b, 8'h00);
    wr(8'h8a, 8'h00);
    wr(8'h8c, 8'hff);
    wr(8'h88, 8'h40);
    wait_bit(1, 40);
    ack(1);
    wr(8'h88, 8'h00);
    rc(8'h8c, 8'h00);
    rc(8'h8a, 8'h00);
    rc(8'h8b, 8'h00);
    wr(8'h89, 8'h20);
    wr(8'h8d, 8'hff);
    // low byte starts at the reload value, so every machine cycle overflows
    wr(8'h8b, 8'hff);
    wr(8'h88, 8'h40);
    wait_bit(4, 40);
    t0 = tdet;
    wait_bit(4, 40);
    chk(8'((tdet - t0) / 25), 8'h0c);
    // land a load on the edge of the next reload; the load must win
    repeat (10) @(negedge sys_clk);
    wr(8'h8b, 8'h5a);
    rc(8'h8b, 8'h5a);
    wr(8'h88, 8'h00);
    $display("split and baud done");
    for (k = 0; k < 2; k++) begin
      wr(8'h88, 8'h01 << (2 * k));
      pm.set_ext(k, 0);
      wait_bit(2 + k, 40);
      ack(2 + k);
      rc(8'h88, 8'h01 << (2 * k));
      pm.set_ext(k, 1);
      wr(8'h88, 8'h00);
      pm.set_ext(k, 0);
      ack(2 + k);
      rc(8'h88, 8'h02 << (2 * k));
      pm.set_ext(k, 1);
      wr(8'h88, 8'h00);
      rc(8'h88, 8'h00);
    end
    $display("external interrupts done");
    print_verdict;
  end
endmodule
